// file: pkg/dbm_pkg.sv
// package for the dual bitstream modulator clocking block
// assumes a single 200 MHz clock; analog inputs arrive as signed digital samples
package dbm_pkg;
  localparam int CLK_MHZ = 200;
  localparam int INT_OSC_MHZ = 20;
  // internal oscillator made by an enable divider from the core clock
  localparam int INT_DIV = CLK_MHZ / INT_OSC_MHZ;
  localparam logic [3:0] INT_DIV_LAST = 4'(INT_DIV - 1);
  localparam int SAMPLE_W = 16;
  // 2.5 V maps to 2^15, so 2 V is 16'sh6666; feedback sits at 2 V / 0.6
  // so that 2 V gives 80 % ones and the loop keeps headroom
  localparam int ACC_W = SAMPLE_W + 4;
  localparam logic signed [ACC_W-1:0] FB_POS = 20'sh0AAAA;
  localparam logic signed [ACC_W-1:0] FB_NEG = -20'sh0AAAA;
  localparam int FIFO_W = 2;
  localparam int FIFO_D = 32;
  localparam logic [1:0] CH_RESET_BITS = 2'h0;
endpackage : dbm_pkg

// file: verilog/dbm_fifo.sv
// fifo with valid/ready on both sides, registered read data
// assumes one clock and synchronous reset copy from the top
module dbm_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_sync_b,
  // write side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // read side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] count;
  logic empty;
  logic do_wr;
  logic do_rd;

  // one entry sits in out_data, so memory occupancy excludes it
  assign count = wr_ptr_reg - rd_ptr_reg;
  assign empty = (count == '0);
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign do_rd = !empty && (!out_valid || out_ready);
  assign do_wr = in_valid && in_ready;

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (do_rd) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_reg[AW-1:0]];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // dbm_fifo

// file: verilog/dbm_top.sv
// two-channel second-order delta-sigma modulator with clock source selection
// assumes inputs synchronous to clock; external clock sampled as a level
// Operation
// - select high runs modulators from internal 20MHz, low from external clock
// - selected system clock divided by two forms the modulator clock
// - one modulator clock output is shared by both channels
// - ones density 50% at zero, 80% at +2V, 20% at -2V
// - per channel: shared clock plus own bitstream output
// - feedback level follows comparator on the next modulator clock
// - each channel samples its input once per modulator clock
module dbm_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // clock source
  input wire logic clock_source_select,
  input wire logic external_clock_input,
  // analog inputs as signed samples, differential already taken
  input wire logic signed [dbm_pkg::SAMPLE_W-1:0] channel_a_input,
  input wire logic signed [dbm_pkg::SAMPLE_W-1:0] channel_b_input,
  // modulator outputs
  output logic modulator_clock_output,
  output logic channel_bitstream_output_a,
  output logic channel_bitstream_output_b
);
  localparam int AW = dbm_pkg::ACC_W;
  logic rst_meta_reg;
  logic rst_sync_b;
  logic [3:0] osc_cnt_reg;
  logic osc_tick;
  logic ext_prev_reg;
  logic sys_edge;
  logic div_reg;
  logic mod_tick;
  logic [1:0] bits_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [1:0] fifo_out_data;
  logic out_phase_reg;
  logic signed [dbm_pkg::SAMPLE_W-1:0] ch_in [2];

  assign ch_in[0] = channel_a_input;
  assign ch_in[1] = channel_b_input;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b <= rst_meta_reg;
    end
  end

  // internal oscillator as a one-cycle enable at 20MHz
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      osc_cnt_reg <= '0;
    end else if (osc_cnt_reg == dbm_pkg::INT_DIV_LAST) begin
      osc_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
    end
  end
  assign osc_tick = (osc_cnt_reg == dbm_pkg::INT_DIV_LAST);

  // external clock rising edge; a static low gives no edges, a static high gives one just after reset
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= external_clock_input;
    end
  end

  // source select; the unused source is ignored entirely
  assign sys_edge = clock_source_select ? osc_tick
                  : (external_clock_input && !ext_prev_reg);

  // divide by two; rising modulator edge is the sampling moment
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div_reg <= 1'b0;
    end else if (sys_edge) begin
      div_reg <= !div_reg;
    end
  end
  assign mod_tick = sys_edge && !div_reg;

  // second-order modulator per channel, one step per modulator clock
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic signed [AW-1:0] int1_reg;
      logic signed [AW-1:0] int2_reg;
      logic fb_reg;
      logic signed [AW-1:0] fb_val;
      logic signed [AW-1:0] x_ext;
      logic signed [AW-1:0] int1_next;
      logic signed [AW-1:0] int2_next;
      assign fb_val = fb_reg ? dbm_pkg::FB_POS : dbm_pkg::FB_NEG;
      assign x_ext = AW'(ch_in[g]);
      // second stage takes the updated first stage: no extra loop delay,
      // which would make the two-integrator loop unstable
      assign int1_next = int1_reg + x_ext - fb_val;
      assign int2_next = int2_reg + int1_next - fb_val;
      // fb_reg holds the comparator decision that drives the feedback level
      assign bits_next[g] = fb_reg;
      always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          int1_reg <= '0;
          int2_reg <= '0;
          fb_reg <= 1'b0;
        end else if (mod_tick) begin
          int1_reg <= int1_next;
          int2_reg <= int2_next;
          fb_reg <= !int2_next[AW-1];
        end
      end
    end
  endgenerate

  // bits leave through the fifo; overflow would need a stalled output
  dbm_fifo #(
    .WIDTH(dbm_pkg::FIFO_W),
    .DEPTH(dbm_pkg::FIFO_D)
  ) u_fifo (
    .clock(clock),
    .rst_sync_b(rst_sync_b),
    .in_valid(mod_tick),
    .in_ready(fifo_in_ready),
    .in_data(bits_next),
    .out_valid(fifo_out_valid),
    .out_ready(out_phase_reg),
    .out_data(fifo_out_data)
  );

  // output stage pops one pair per modulator period
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_phase_reg <= 1'b0;
    end else begin
      out_phase_reg <= mod_tick && fifo_in_ready;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      modulator_clock_output <= 1'b0;
      channel_bitstream_output_a <= dbm_pkg::CH_RESET_BITS[0];
      channel_bitstream_output_b <= dbm_pkg::CH_RESET_BITS[1];
    end else begin
      modulator_clock_output <= div_reg;
      if (fifo_out_valid && out_phase_reg) begin
        channel_bitstream_output_a <= fifo_out_data[0];
        channel_bitstream_output_b <= fifo_out_data[1];
      end
    end
  end
endmodule // dbm_top

// file: dv/dbm_checker.sv
// timing checks on the modulator clock and both bitstreams
// bound to dbm_top; mode changes only happen while reset is held
module dbm_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // watched ports
  input wire logic clock_source_select,
  input wire logic external_clock_input,
  input wire logic signed [dbm_pkg::SAMPLE_W-1:0] channel_a_input,
  input wire logic modulator_clock_output,
  input wire logic channel_bitstream_output_a,
  input wire logic channel_bitstream_output_b
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  int_high_a: assert property ($rose(modulator_clock_output) && clock_source_select |=>
    $stable(modulator_clock_output)[*8] ##1 $stable(modulator_clock_output)
    ##1 $fell(modulator_clock_output)) else $error("internal high phase wrong");
  int_low_a: assert property ($fell(modulator_clock_output) && clock_source_select |=>
    $stable(modulator_clock_output)[*8] ##1 $stable(modulator_clock_output)
    ##1 $rose(modulator_clock_output)) else $error("internal low phase wrong");
  ext_div_a: assert property (!clock_source_select && $rose(external_clock_input)
    |-> ##[1:4] $changed(modulator_clock_output)) else $error("external edge lost");
  bit_align_a: assert property ($changed(channel_bitstream_output_a) ||
    $changed(channel_bitstream_output_b) |-> modulator_clock_output) else $error("bit off phase");
  one_bit_a: assert property ($changed(channel_bitstream_output_a) |=>
    $stable(channel_bitstream_output_a)[*8]) else $error("channel a bit too short");
  one_bit_b_a: assert property ($changed(channel_bitstream_output_b) |=>
    $stable(channel_bitstream_output_b)[*8]) else $error("channel b bit too short");
  zero_mix_a: assert property (clock_source_select && channel_a_input == 0 &&
    $rose(channel_bitstream_output_a) |-> ##[1:80] $fell(channel_bitstream_output_a))
    else $error("zero input stuck high");
  cover property (!clock_source_select && $rose(modulator_clock_output));
  cover property (channel_a_input > 0 && $rose(channel_bitstream_output_a));
  cover property (channel_a_input < 0 && $fell(channel_bitstream_output_b));
endmodule // dbm_checker
bind dbm_top dbm_checker u_dbm_checker (.*);

// file: dv/dbm_capture.sv
// far-side capture model: counts bits and ones per channel over a window
// assumes bits settle well before the modulator clock falls
module dbm_capture (
  // link
  input wire logic mod_clk,
  input wire logic bit_a,
  input wire logic bit_b,
  // window control and counts
  input wire logic clear,
  output int ones_a,
  output int ones_b,
  output int n_bits
);
  // mid-period sampling keeps clear of the update after the rising edge
  always @(negedge mod_clk or posedge clear) begin
    if (clear) begin
      ones_a <= 0;
      ones_b <= 0;
      n_bits <= 0;
    end else begin
      ones_a <= ones_a + int'(bit_a);
      ones_b <= ones_b + int'(bit_b);
      n_bits <= n_bits + 1;
    end
  end
endmodule // dbm_capture

// file: dv/test_dual_bitstream_modulator_clocking.sv
// bench for dbm_top: source modes, modulator period, ones density
// external clock runs at 10 MHz only in external mode, static otherwise
module test_dual_bitstream_modulator_clocking;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_b = 0, sel = 1, ext = 0, clear = 0, mclk, bit_a, bit_b;
  logic signed [dbm_pkg::SAMPLE_W-1:0] a_in = '0, b_in = '0;
  int ones_a, ones_b, n_bits, n_fail = 0, checks = 0, cyc = 0, ext_cnt = 0;
  initial forever #2.5 clock = ~clock;
  dbm_top u_dbm_top (.clock(clock), .rst_b(rst_b), .clock_source_select(sel),
    .external_clock_input(ext), .channel_a_input(a_in), .channel_b_input(b_in),
    .modulator_clock_output(mclk), .channel_bitstream_output_a(bit_a),
    .channel_bitstream_output_b(bit_b));
  dbm_capture u_dbm_capture (.mod_clk(mclk), .bit_a(bit_a), .bit_b(bit_b),
    .clear(clear), .ones_a(ones_a), .ones_b(ones_b), .n_bits(n_bits));
  always @(posedge clock) begin
    ext_cnt <= (sel || !rst_b || ext_cnt == 9) ? 0 : ext_cnt + 1;
    if (!sel && rst_b && ext_cnt == 9) ext <= ~ext;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t: saw %0d expected %0d", $time, seen, exp);
    end
  endtask
  task automatic start(input logic mode);
    rst_b <= 0;
    sel <= mode;
    repeat (12) @(posedge clock);
    rst_b <= 1;
    repeat (4) @(posedge clock);
  endtask
  task automatic period(input int exp);
    time t0;
    @(posedge mclk);
    t0 = $time;
    @(posedge mclk);
    chk(32'(($time - t0) / 5), exp);
  endtask
  task automatic density(input logic signed [dbm_pkg::SAMPLE_W-1:0] in, input int pct);
    a_in <= in;
    b_in <= -in;
    repeat (200) @(posedge clock);
    clear <= 1;
    @(posedge clock);
    clear <= 0;
    wait (n_bits == 100);
    chk(32'(ones_a inside {[pct-4:pct+4]}), 1);
    chk(32'(ones_b inside {[96-pct:104-pct]}), 1);
  endtask
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    start(1'b1);
    period(20);
    density(16'sh0, 50);
    density(16'sh6666, 80);
    start(1'b0);
    period(40);
    density(-16'sh6666, 20);
    give_verdict();
  end
endmodule // test_dual_bitstream_modulator_clocking
